// ### rtl/qcm_pkg.sv
/*
 * Constants of the queue congestion monitor: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 10 MHz register clock and 32-bit AHB-Lite data.
 */
package qcm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned LEVEL_W = 8;   // Queue occupancy width
    localparam int unsigned CNT_W   = 16;  // Counter and limit width
    localparam int unsigned ADDR_W  = 8;   // Decoded address bits

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EGR_CFG  = 8'h00; // egress_level_config
    localparam logic [7:0] OFS_EGR_BUSY = 8'h04; // egress_busy_tick_counter
    localparam logic [7:0] OFS_EGR_OVF  = 8'h08; // egress_overfill_status
    localparam logic [7:0] OFS_REORDER  = 8'h0c; // reorder_tracking
    localparam logic [7:0] OFS_ING_CFG  = 8'h10; // ingress_level_config
    localparam logic [7:0] OFS_ING_BUSY = 8'h14; // ingress_busy_tick_counter
    localparam logic [7:0] OFS_ING_OVF  = 8'h18; // ingress_overfill_status
    localparam logic [7:0] OFS_INT_STAT = 8'h1c; // Port interrupt status
    localparam logic [7:0] OFS_INT_MASK = 8'h20; // Port interrupt mask

    // ------------------------------------------------------------
    // Level config fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_LEVEL_LSB = 0;   // queue_level_limit
    localparam int unsigned CFG_DRAIN_LSB = 8;   // drain_tick_interval
    localparam int unsigned CFG_BUSY_LSB  = 16;  // busy_tick_interval
    localparam int unsigned CFG_LONG_BIT  = 24;  // long_tick_select
    localparam int unsigned CFG_W         = 25;
    localparam logic [24:0] CFG_RST       = 25'h0000000;

    // ------------------------------------------------------------
    // Interrupt status and mask bits
    // ------------------------------------------------------------
    localparam int unsigned INT_EGR_BIT = 0;  // egress_overfill_flag
    localparam int unsigned INT_ING_BIT = 1;  // Ingress overfill flag
    localparam int unsigned INT_REO_BIT = 2;  // ingress_reorder_flag
    localparam int unsigned INT_W       = 3;
    localparam logic [2:0]  INT_RST     = 3'h0;
    localparam logic [15:0] LIMIT_RST   = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ      = 10000; // hclk rate
    localparam int unsigned LONG_UNIT_NS = 1500;  // Long base unit
    localparam int unsigned LONG_UNIT_CYC_I = (LONG_UNIT_NS * CLK_KHZ) / 1000000;
    localparam logic [7:0]  LONG_UNIT_CYC =
        (LONG_UNIT_CYC_I < 1) ? 8'h01 : LONG_UNIT_CYC_I[7:0];

endpackage : qcm_pkg

// ### rtl/qcm_queue_mon.sv
/*
 * One queue's overfill counter, drain tick timer and busy-tick
 * counter. Used once for the egress and once for the ingress queue.
 * Assumes configuration is held in registers of the parent.
 */
module qcm_queue_mon (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // Queue side
    input  wire logic [7:0]  level,
    input  wire logic        pkt_done,
    // Configuration
    input  wire logic [7:0]  level_limit,
    input  wire logic [7:0]  drain_ivl,
    input  wire logic [7:0]  busy_ivl,
    input  wire logic        long_sel,
    input  wire logic [15:0] overfill_limit,
    input  wire logic [15:0] busy_limit,
    // Software actions
    input  wire logic        flag_clr,
    input  wire logic        busy_rd_clr,
    // Results
    output logic      [15:0] overfill_count,
    output logic      [31:0] busy_count,
    output logic             flag_set
);

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic [7:0] unit_r;      // Long base unit prescaler
    logic [7:0] busy_tmr_r;  // Busy-tick interval timer
    logic [7:0] drain_tmr_r; // Drain interval timer
    logic       base_tick;   // One base unit elapsed
    logic       busy_tick;   // Busy-tick expiry
    logic       drain_tick;  // Drain tick
    logic       ovf_inc;     // Overfill increment event
    logic       ovf_dec;     // Overfill decrement event
    logic       busy_inc;    // Busy count increment event

    // Base unit is one cycle, or about 1.5 us in long mode
    always_comb base_tick = !long_sel || (unit_r == qcm_pkg::LONG_UNIT_CYC - 8'h01); // RULE_05
    always_comb busy_tick = base_tick && (busy_tmr_r >= busy_ivl);                   // RULE_02
    // A zero drain interval stops draining altogether
    always_comb drain_tick = (drain_ivl != 8'h00) && (drain_tmr_r >= drain_ivl);     // RULE_04

    // Prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_r <= 8'h00;
        end else if (clk_en) begin
            unit_r <= base_tick ? 8'h00 : unit_r + 8'h01;
        end
    end

    // Busy-tick interval: busy_ivl + 1 base units
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_tmr_r <= 8'h00;
        end else if (clk_en && base_tick) begin
            busy_tmr_r <= busy_tick ? 8'h00 : busy_tmr_r + 8'h01;
        end
    end

    // Drain interval: drain_ivl + 1 cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drain_tmr_r <= 8'h00;
        end else if (clk_en) begin
            drain_tmr_r <= drain_tick ? 8'h00 : drain_tmr_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Overfill counter
    // ------------------------------------------------------------
    // Compared only when a packet has fully landed in the buffer
    always_comb ovf_inc = pkt_done && (level > level_limit);                  // RULE_03
    always_comb ovf_dec = drain_tick && (overfill_count != 16'h0000);         // RULE_18

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overfill_count <= 16'h0000;
        end else if (clk_en) begin
            if (flag_clr) begin
                overfill_count <= 16'h0000;                                   // RULE_10
            end else if (ovf_inc && !ovf_dec && overfill_count != 16'hffff) begin
                overfill_count <= overfill_count + 16'h0001;                  // RULE_03
            end else if (ovf_dec && !ovf_inc) begin
                overfill_count <= overfill_count - 16'h0001;                  // RULE_04
            end
        end
    end

    // ------------------------------------------------------------
    // Busy-tick counter
    // ------------------------------------------------------------
    always_comb busy_inc = busy_tick && (overfill_count != 16'h0000);         // RULE_02

    // A tick landing on the clearing cycle is kept as a count of one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_count <= 32'h00000000;
        end else if (clk_en) begin
            if (!long_sel) begin
                if (busy_rd_clr) begin
                    busy_count <= {31'h00000000, busy_inc};                   // RULE_07
                end else if (busy_inc && busy_count != 32'hffffffff) begin
                    busy_count <= busy_count + 32'h00000001;                  // RULE_06
                end
            end else begin
                if (flag_clr) begin
                    busy_count <= {31'h00000000, busy_inc};                   // RULE_08
                end else if (busy_inc && busy_count[15:0] != 16'hffff) begin
                    busy_count <= {16'h0000, busy_count[15:0] + 16'h0001};    // RULE_06
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Flag condition, held as a level while true
    // ------------------------------------------------------------
    always_comb flag_set = (overfill_count > overfill_limit)                  // RULE_11
        || (long_sel && busy_limit != 16'h0000
            && busy_count[15:0] >= busy_limit);                               // RULE_09

endmodule : qcm_queue_mon

// ### rtl/qcm_top.sv
/*
 * Per-port queue congestion monitor with an AHB-Lite register slave.
 * Holds egress and ingress monitors, the reorder counter, the port
 * interrupt status and mask, and the port-write request.
 * Assumes queue and fabric strobes are synchronous to hclk.
 */
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
// Summary of operation
// RULE_01 - Port has separate egress and ingress monitor sets
// RULE_02 - Busy-tick expiry counts while overfill nonzero
// RULE_03 - Overfill counts on packet completion over limit
// RULE_04 - Drain tick decrements overfill count
// RULE_05 - Long select stretches busy base unit
// RULE_06 - Busy count saturates, never wraps
// RULE_07 - Short mode: 32-bit busy count, read clears
// RULE_08 - Long mode: 16-bit, cleared by flag write
// RULE_09 - Long mode busy count reaching limit sets flag
// RULE_10 - Writing egress flag one clears overfill count
// RULE_11 - Overfill count above limit sets flag
// RULE_12 - Fabric picking non-head packet counts reorder
// RULE_13 - Reorder count reaching limit sets reorder flag
// RULE_14 - Ingress registers mirror egress behaviour
// RULE_15 - Ingress and egress depth interrupt bits
// RULE_16 - Egress flag raises port-write request
// RULE_17 - Software polls counters for congestion trend
// RULE_18 - Overfill floors at zero; inc plus drain holds
module qcm_top (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Egress queue
    input  wire logic [7:0]  egr_level,
    input  wire logic        egr_pkt_done,
    // Ingress queue
    input  wire logic [7:0]  ing_level,
    input  wire logic        ing_pkt_done,
    // Switch fabric selection
    input  wire logic        fabric_pick,
    input  wire logic        fabric_pick_not_head,
    // Notification
    output logic             irq,
    output logic             port_write_req
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [24:0] egr_cfg_r;   // egress_level_config
    logic [24:0] ing_cfg_r;   // ingress_level_config
    logic [15:0] egr_blim_r;  // Egress busy_tick_limit
    logic [15:0] ing_blim_r;  // Ingress busy_tick_limit
    logic [15:0] egr_olim_r;  // Egress overfill_limit
    logic [15:0] ing_olim_r;  // Ingress overfill_limit
    logic [15:0] reo_lim_r;   // reorder_limit
    logic [15:0] reo_cnt_r;   // reorder_count
    logic [2:0]  int_stat_r;  // Sticky interrupt status
    logic [2:0]  int_mask_r;  // Interrupt enables
    logic [31:0] hrdata_r;    // Read data for the data phase
    logic        irq_r;       // Registered interrupt level
    logic        pw_r;        // Port-write request pulse

    // ------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------
    logic        dp_wr_r;     // Write data phase pending
    logic [7:0]  dp_addr_r;   // Address of that write
    logic        acc;         // Transfer taken this cycle
    logic        rd_acc;      // Read taken this cycle
    logic        wr_en;       // Write data present now
    logic [31:0] rd_mux;      // Read data selection

    // ------------------------------------------------------------
    // Monitor results and events
    // ------------------------------------------------------------
    logic [15:0] egr_ovf_cnt; // Egress overfill_count
    logic [15:0] ing_ovf_cnt; // Ingress overfill_count
    logic [31:0] egr_busy;    // Egress busy_tick_count
    logic [31:0] ing_busy;    // Ingress busy_tick_count
    logic        egr_set;     // Egress flag condition
    logic        ing_set;     // Ingress flag condition
    logic        reo_set;     // Reorder flag condition
    logic        reo_inc;     // Reorder event
    logic [2:0]  int_clr;     // Write-one-to-clear bits
    logic [2:0]  int_set;     // Hardware set bits
    logic        egr_rd_clr;  // Read of egress busy counter
    logic        ing_rd_clr;  // Read of ingress busy counter

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Stalling while frozen keeps transfers from being dropped
    always_comb hreadyout = clk_en;
    // Every access is answered OKAY, unmapped ones included
    always_comb hresp     = 1'b0;
    always_comb hrdata    = hrdata_r;
    always_comb acc       = hsel && hready && htrans[1];
    always_comb rd_acc    = acc && !hwrite;
    always_comb wr_en     = dp_wr_r;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (clk_en) begin
            dp_wr_r   <= acc && hwrite;
            dp_addr_r <= haddr[7:0];
        end
    end

    // Read data selection, zero for unmapped words
    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr[7:0] == qcm_pkg::OFS_EGR_CFG) begin
            rd_mux = {7'h00, egr_cfg_r};
        end else if (haddr[7:0] == qcm_pkg::OFS_EGR_BUSY) begin
            // Short mode shows the full 32-bit count
            rd_mux = egr_cfg_r[qcm_pkg::CFG_LONG_BIT] ?
                     {egr_blim_r, egr_busy[15:0]} : egr_busy;       // RULE_07
        end else if (haddr[7:0] == qcm_pkg::OFS_EGR_OVF) begin
            rd_mux = {egr_olim_r, egr_ovf_cnt};                     // RULE_17
        end else if (haddr[7:0] == qcm_pkg::OFS_REORDER) begin
            rd_mux = {reo_lim_r, reo_cnt_r};
        end else if (haddr[7:0] == qcm_pkg::OFS_ING_CFG) begin
            rd_mux = {7'h00, ing_cfg_r};
        end else if (haddr[7:0] == qcm_pkg::OFS_ING_BUSY) begin
            rd_mux = ing_cfg_r[qcm_pkg::CFG_LONG_BIT] ?
                     {ing_blim_r, ing_busy[15:0]} : ing_busy;       // RULE_14
        end else if (haddr[7:0] == qcm_pkg::OFS_ING_OVF) begin
            rd_mux = {ing_olim_r, ing_ovf_cnt};
        end else if (haddr[7:0] == qcm_pkg::OFS_INT_STAT) begin
            rd_mux = {29'h00000000, int_stat_r};
        end else if (haddr[7:0] == qcm_pkg::OFS_INT_MASK) begin
            rd_mux = {29'h00000000, int_mask_r};
        end
    end

    // Read data is latched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (clk_en && rd_acc) begin
            hrdata_r <= rd_mux;
        end
    end

    // Read-clear applies only in short mode, on the sampled read
    always_comb egr_rd_clr = rd_acc && haddr[7:0] == qcm_pkg::OFS_EGR_BUSY; // RULE_07
    always_comb ing_rd_clr = rd_acc && haddr[7:0] == qcm_pkg::OFS_ING_BUSY; // RULE_14

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Level configs; upper bits not stored read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            egr_cfg_r <= qcm_pkg::CFG_RST;
            ing_cfg_r <= qcm_pkg::CFG_RST;
        end else if (clk_en && wr_en) begin
            if (dp_addr_r == qcm_pkg::OFS_EGR_CFG) begin
                egr_cfg_r <= hwdata[24:0];
            end else if (dp_addr_r == qcm_pkg::OFS_ING_CFG) begin
                ing_cfg_r <= hwdata[24:0];                          // RULE_14
            end
        end
    end

    // Limits share the upper half of their counter registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            egr_blim_r <= qcm_pkg::LIMIT_RST;
            ing_blim_r <= qcm_pkg::LIMIT_RST;
            egr_olim_r <= qcm_pkg::LIMIT_RST;
            ing_olim_r <= qcm_pkg::LIMIT_RST;
            reo_lim_r  <= qcm_pkg::LIMIT_RST;
        end else if (clk_en && wr_en) begin
            if (dp_addr_r == qcm_pkg::OFS_EGR_BUSY) begin
                egr_blim_r <= hwdata[31:16];
            end else if (dp_addr_r == qcm_pkg::OFS_ING_BUSY) begin
                ing_blim_r <= hwdata[31:16];
            end else if (dp_addr_r == qcm_pkg::OFS_EGR_OVF) begin
                egr_olim_r <= hwdata[31:16];
            end else if (dp_addr_r == qcm_pkg::OFS_ING_OVF) begin
                ing_olim_r <= hwdata[31:16];
            end else if (dp_addr_r == qcm_pkg::OFS_REORDER) begin
                reo_lim_r  <= hwdata[31:16];
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask_r <= qcm_pkg::INT_RST;
        end else if (clk_en && wr_en && dp_addr_r == qcm_pkg::OFS_INT_MASK) begin
            int_mask_r <= hwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Queue monitors, one per direction
    // ------------------------------------------------------------
    always_comb int_clr = (wr_en && dp_addr_r == qcm_pkg::OFS_INT_STAT) ?
                          hwdata[2:0] : 3'h0;

    // Egress queue
    qcm_queue_mon u_egr (                                            // RULE_01
        .hclk           (hclk),
        .hresetn        (hresetn),
        .clk_en         (clk_en),
        .level          (egr_level),
        .pkt_done       (egr_pkt_done),
        .level_limit    (egr_cfg_r[qcm_pkg::CFG_LEVEL_LSB +: 8]),
        .drain_ivl      (egr_cfg_r[qcm_pkg::CFG_DRAIN_LSB +: 8]),
        .busy_ivl       (egr_cfg_r[qcm_pkg::CFG_BUSY_LSB +: 8]),
        .long_sel       (egr_cfg_r[qcm_pkg::CFG_LONG_BIT]),
        .overfill_limit (egr_olim_r),
        .busy_limit     (egr_blim_r),
        .flag_clr       (int_clr[qcm_pkg::INT_EGR_BIT]),
        .busy_rd_clr    (egr_rd_clr),
        .overfill_count (egr_ovf_cnt),
        .busy_count     (egr_busy),
        .flag_set       (egr_set)
    );

    // Ingress queue, same behaviour on ingress occupancy
    qcm_queue_mon u_ing (                                            // RULE_14
        .hclk           (hclk),
        .hresetn        (hresetn),
        .clk_en         (clk_en),
        .level          (ing_level),
        .pkt_done       (ing_pkt_done),
        .level_limit    (ing_cfg_r[qcm_pkg::CFG_LEVEL_LSB +: 8]),
        .drain_ivl      (ing_cfg_r[qcm_pkg::CFG_DRAIN_LSB +: 8]),
        .busy_ivl       (ing_cfg_r[qcm_pkg::CFG_BUSY_LSB +: 8]),
        .long_sel       (ing_cfg_r[qcm_pkg::CFG_LONG_BIT]),
        .overfill_limit (ing_olim_r),
        .busy_limit     (ing_blim_r),
        .flag_clr       (int_clr[qcm_pkg::INT_ING_BIT]),
        .busy_rd_clr    (ing_rd_clr),
        .overfill_count (ing_ovf_cnt),
        .busy_count     (ing_busy),
        .flag_set       (ing_set)
    );

    // ------------------------------------------------------------
    // Reorder tracking
    // ------------------------------------------------------------
    always_comb reo_inc = fabric_pick && fabric_pick_not_head;      // RULE_12
    always_comb reo_set = (reo_lim_r != 16'h0000) && (reo_cnt_r >= reo_lim_r); // RULE_13

    // Saturating; cleared with its status bit, an event then still counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reo_cnt_r <= 16'h0000;
        end else if (clk_en) begin
            if (int_clr[qcm_pkg::INT_REO_BIT]) begin
                reo_cnt_r <= {15'h0000, reo_inc};
            end else if (reo_inc && reo_cnt_r != 16'hffff) begin
                reo_cnt_r <= reo_cnt_r + 16'h0001;                  // RULE_12
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    // A write-one clear also zeroes the count behind that condition,
    // so the stale condition must not re-set the bit on that edge
    always_comb int_set = {reo_set, ing_set, egr_set} & ~int_clr;   // RULE_15

    // Hardware sets hold the bit until software clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat_r <= qcm_pkg::INT_RST;
        end else if (clk_en) begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;        // RULE_15
        end
    end

    // Interrupt level lags status by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end
    always_comb irq = irq_r;

    // ------------------------------------------------------------
    // Port-write request
    // ------------------------------------------------------------
    // One pulse when the egress flag goes from clear to set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw_r <= 1'b0;
        end else if (clk_en) begin
            pw_r <= egr_set && !int_stat_r[qcm_pkg::INT_EGR_BIT];    // RULE_16
        end
    end
    always_comb port_write_req = pw_r;

endmodule : qcm_top

// ### test/qcm_top_sva.sv
/* Port checker for qcm_top; assumes a single hclk domain. */
module qcm_sva (
    // Watched ports
    input wire logic        hclk, hresetn, clk_en, hsel, hwrite, hready,
    input wire logic [1:0]  htrans,
    input wire logic        hreadyout, hresp, irq, port_write_req,
    input wire logic [31:0] hrdata, haddr
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_ready_follow: assert property (hreadyout == clk_en) else $error("hreadyout off");
    chk_pw_pulse: assert property (port_write_req && clk_en |=> !port_write_req)
        else $error("port write not a pulse");
    chk_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite && clk_en)
        |=> $stable(hrdata)) else $error("hrdata moved without read");
    chk_freeze_out: assert property (!clk_en |=> $stable(irq) && $stable(port_write_req))
        else $error("outputs moved while frozen");
    chk_rdata_unmapped: assert property (hsel && hready && htrans[1] && !hwrite && clk_en
        && haddr[7:0] > 8'h20 |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule : qcm_sva
bind qcm_top qcm_sva u_sva (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .htrans(htrans), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .port_write_req(port_write_req), .hrdata(hrdata), .haddr(haddr));

// ### test/qcm_queue_model.sv
/* Queue model: completion strobe with its level; assumes hclk timing. */
module qcm_queue_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       push,
    input  wire logic [7:0] push_lvl,
    output logic      [7:0] level,
    output logic            pkt_done
);
    // Level stands in the same cycle as its completion pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= 8'h00;
            pkt_done <= 1'b0;
        end else begin
            pkt_done <= push;
            if (push) level <= push_lvl;
        end
    end
endmodule : qcm_queue_model

// ### test/tb_top.sv
/* Bench for qcm_top; assumes zero-wait AHB-Lite slave. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, irq, pwr, pe = 1'b0, pi = 1'b0, pick = 1'b0, nh = 1'b0, ed, id;
    logic [7:0] lvl = 8'h00, el, il;
    int n_mismatch = 0, check_count = 0, n_pw = 0;
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (pwr === 1'b1) n_pw++; // Port-write pulses seen
    qcm_queue_model u_eq (.hclk(hclk), .hresetn(hresetn), .push(pe), .push_lvl(lvl),
        .level(el), .pkt_done(ed));
    qcm_queue_model u_iq (.hclk(hclk), .hresetn(hresetn), .push(pi), .push_lvl(lvl),
        .level(il), .pkt_done(id));
    qcm_top u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .egr_level(el),
        .egr_pkt_done(ed), .ing_level(il), .ing_pkt_done(id), .fabric_pick(pick),
        .fabric_pick_not_head(nh), .irq(irq), .port_write_req(pwr));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // One single word transfer, waiting on hready in both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task push(input logic q, input logic [7:0] v);
        lvl <= v; pe <= !q; pi <= q;
        @(posedge hclk); pe <= 1'b0; pi <= 1'b0; @(posedge hclk);
    endtask : push
    // Queue q: 0 egress, 1 ingress; limit 4, overfill limit 2
    task t_queue(input logic q);
        logic [7:0] b;
        b = q ? 8'h10 : 8'h00;
        bus(1, qcm_pkg::OFS_EGR_CFG + b, 32'h4);
        bus(1, qcm_pkg::OFS_EGR_OVF + b, 32'h0002_0000);
        bus(1, qcm_pkg::OFS_INT_MASK, 32'h3);
        repeat (3) push(q, 8'h05);
        push(q, 8'h04);
        bus(0, qcm_pkg::OFS_EGR_OVF + b, 0); chk("ovf", 32'h20003, rd);
        bus(0, qcm_pkg::OFS_INT_STAT, 0); chk("stat", 32'h1 << q, rd & 32'h3);
        chk("irq", 1, irq);
        chk("pw", 1, n_pw);
        bus(1, qcm_pkg::OFS_INT_STAT, 32'h1 << q);
        bus(0, qcm_pkg::OFS_EGR_OVF + b, 0); chk("clr", 32'h20000, rd);
        bus(1, qcm_pkg::OFS_EGR_CFG + b, 32'h104);
        push(q, 8'h05);
        repeat (3) @(posedge hclk);
        bus(0, qcm_pkg::OFS_EGR_OVF + b, 0);
        chk("drain", 32'h20000, rd);
        bus(0, qcm_pkg::OFS_EGR_BUSY + b, 0);
        chk("busy run", 1, |rd);
        bus(0, qcm_pkg::OFS_EGR_BUSY + b, 0); chk("busy", 0, rd);
        chk("irq off", 0, irq);
        $display("queue test %0d done", q);
    endtask : t_queue
    // Two non-head picks reach a reorder limit of 2
    task t_reorder;
        bus(1, qcm_pkg::OFS_REORDER, 32'h0002_0000);
        pick <= 1'b1; @(posedge hclk); nh <= 1'b1; repeat (2) @(posedge hclk);
        pick <= 1'b0; nh <= 1'b0; clk_en <= 1'b0; repeat (3) @(posedge hclk);
        clk_en <= 1'b1; @(posedge hclk);
        bus(0, qcm_pkg::OFS_REORDER, 0); chk("reo", 32'h20002, rd);
        bus(0, qcm_pkg::OFS_INT_STAT, 0); chk("reo flag", 32'h4, rd & 32'h4);
        bus(0, 8'h40, 0); chk("unmapped", 0, rd);
        $display("reorder test done");
    endtask : t_reorder
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_queue(0); t_queue(1); t_reorder;
        tally_and_finish;
    end
    initial begin
        #1000000; n_mismatch++; tally_and_finish;
    end
endmodule : tb_top
